// ==== logic/vmc_pkg.sv ====
// constants and types for the vfd multiplex controller
`default_nettype none
package vmc_pkg;
    // two-wire slave address, upper bits fixed
    localparam logic [4:0] VMC_ADDR_HI = 5'h1d;
    // value is arbitrary, identifies the driver type on readback
    localparam logic [6:0] VMC_DEV_ID = 7'h2a;
    // register pointer locations
    localparam logic [6:0] VMC_REG_POL = 7'h01;
    localparam logic [6:0] VMC_REG_INT = 7'h02;
    localparam logic [6:0] VMC_REG_GRID = 7'h03;
    localparam logic [6:0] VMC_REG_CFG = 7'h04;
    localparam logic [6:0] VMC_REG_FONT = 7'h05;
    localparam logic [6:0] VMC_REG_MAP = 7'h06;
    localparam logic [6:0] VMC_REG_TEST = 7'h07;
    localparam logic [6:0] VMC_REG_LIMIT = 7'h0e;
    localparam logic [6:0] VMC_REG_HOLD = 7'h7f;
    // field positions
    localparam int VMC_POL_BIT = 1;
    localparam int VMC_RUN_BIT = 0;
    localparam int VMC_TEST_BIT = 0;
    // clamps and reset values
    localparam logic [7:0] VMC_GRID_MAX = 8'h2f;
    localparam logic [7:0] VMC_LIMIT_MAX = 8'h53;
    localparam logic [7:0] VMC_GRID_RST = 8'h00;
    localparam logic [7:0] VMC_LIMIT_RST = 8'h53;
    localparam logic [3:0] VMC_INT_RST = 4'h0;
    localparam logic [3:0] VMC_TEST_INT = 4'h6;
    localparam logic [3:0] VMC_INT_FULL = 4'hf;
    localparam logic [6:0] VMC_MAP_LAST = 7'h53;
    // multiplex timing
    localparam int VMC_CLK_HZ = 100_000_000;
    localparam int VMC_BLANK_MIN_NS = 6250;
    localparam int VMC_SLOT_CYC =
        (VMC_BLANK_MIN_NS * (VMC_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int VMC_SHIFT_DIV = 4;
    localparam logic [15:0] VMC_LOAD_CYC = 16'h0004;
    // events handed from the link domain to the core
    typedef enum logic [1:0] {
        VMC_EV_CMD,
        VMC_EV_WR,
        VMC_EV_RD
    } vmc_ev_e;
    typedef enum logic [2:0] {
        VMC_LK_ADDR,
        VMC_LK_CMD,
        VMC_LK_WDATA,
        VMC_LK_READ,
        VMC_LK_IDLE
    } vmc_link_e;
endpackage
`default_nettype wire

// ==== logic/vmc_mux_ctrl.sv ====
// vfd multiplex controller with two-wire register port
// Operation
// - command byte alone only sets pointer
// - first data byte goes to pointed register
// - reads start at pointer, then advance
// - pointer increments in ordinary ranges
// - 0x05/0x06 hold pointer, step memory pointer
// - pointer 0x7f never moves
// - shift clock is core clock over four
// - stream length set by shift limit
// - data changes on falling shift edge
// - latch load high passes, low holds
// - blank polarity programmable, default high disables
// - blank gives pwm, disables in shutdown
// - next grid shifted during current slot
// - latch load pulses at cycle start
// - grid count holds grids minus one
// - first cycle after grid write blanked
// - grid count above 0x2f stores 0x2f
// - address is 11101 plus select bits
// - polarity bit 1 selects blank level
// - shift limit above 0x53 stores 0x53
// - each period opens with blanked sixteenth
`default_nettype none
module vmc_mux_ctrl
    import vmc_pkg::*;
#(
    parameter int SLOT_CYCLES = VMC_SLOT_CYC
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [1:0] addr_select_pin_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic tube_shift_clock_out,
    output logic tube_serial_out_out,
    output logic tube_latch_load_out,
    output logic tube_blank_gate_out
);
    localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYCLES - 1);
    localparam logic [1:0] PH_LAST = 2'(VMC_SHIFT_DIV - 1);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers and frame detection, core domain
    logic scl_s1, scl_s2, sda_s1, sda_s2, sda_s3;
    logic [1:0] adr_s1, adr_s2, dev_sel;
    logic frame_clr;
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {scl_s1, scl_s2} <= 2'h3; // idle high, no false low after reset
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
            adr_s1 <= 2'h0;
            adr_s2 <= 2'h0;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            adr_s1 <= addr_select_pin_in;
            adr_s2 <= adr_s1;
        end
    end

    wire start_det = scl_s2 & sda_s3 & ~sda_s2;
    wire stop_det = scl_s2 & ~sda_s3 & sda_s2;

    // frame_clr holds the link logic in reset between frames; it drops
    // while scl is low after a start, long before the first scl rise
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frame_clr <= 1'b1;
            dev_sel <= 2'h0;
        end else begin
            if (start_det | stop_det)
                frame_clr <= 1'b1;
            else if (!scl_s2)
                frame_clr <= 1'b0;
            if (frame_clr)
                dev_sel <= adr_s2; // strap frozen for the frame
        end
    end

    ////////////////////////////////////////////////////////////////////
    // link domain, clocked by scl
    wire link_rst_n = resetn_in & ~frame_clr;
    vmc_link_e lstate;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic ack_pend, sda_oe, ev_tog;
    vmc_ev_e ev_kind;
    logic [7:0] ev_byte;
    logic [7:0] rd_byte;

    wire [7:0] rx_byte = {shreg[6:0], sda_in};
    wire byte_end = bit_cnt == 4'h7;
    wire ack_edge = bit_cnt == 4'h8;
    wire addr_hit = rx_byte[7:1] == {VMC_ADDR_HI, dev_sel};
    wire in_read = lstate == VMC_LK_READ;
    wire fire_cmd = byte_end & (lstate == VMC_LK_CMD);
    wire fire_wr = byte_end & (lstate == VMC_LK_WDATA);
    wire fire_rd = byte_end & in_read; // early, so the next msb is fresh
    wire rd_bit = rd_byte[~bit_cnt[2:0]];

    // bit counter and transaction state
    always_ff @(posedge scl_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lstate <= VMC_LK_ADDR;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            ack_pend <= 1'b0;
        end else if (ack_edge) begin
            bit_cnt <= 4'h0;
            ack_pend <= 1'b0;
            if (in_read & ~ack_pend & sda_in)
                lstate <= VMC_LK_IDLE; // master nack ends the read
        end else begin
            bit_cnt <= bit_cnt + 4'h1;
            shreg <= rx_byte;
            if (byte_end) begin
                unique case (lstate)
                    VMC_LK_ADDR: begin
                        ack_pend <= addr_hit;
                        if (!addr_hit)
                            lstate <= VMC_LK_IDLE;
                        else if (rx_byte[0])
                            lstate <= VMC_LK_READ;
                        else
                            lstate <= VMC_LK_CMD;
                    end
                    VMC_LK_CMD: begin
                        ack_pend <= 1'b1;
                        lstate <= VMC_LK_WDATA;
                    end
                    VMC_LK_WDATA: ack_pend <= 1'b1;
                    VMC_LK_READ, VMC_LK_IDLE: ack_pend <= 1'b0;
                endcase
            end
        end
    end

    // event toggle survives frame boundaries so no edge is faked
    always_ff @(posedge scl_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ev_tog <= 1'b0;
            ev_kind <= VMC_EV_CMD;
            ev_byte <= 8'h00;
        end else if (fire_cmd | fire_wr | fire_rd) begin
            ev_tog <= ~ev_tog;
            ev_byte <= rx_byte;
            if (fire_cmd)
                ev_kind <= VMC_EV_CMD;
            else if (fire_wr)
                ev_kind <= VMC_EV_WR;
            else
                ev_kind <= VMC_EV_RD;
        end
    end

    // sda driven on falling scl: ack, then read data msb first
    always_ff @(negedge scl_in or negedge link_rst_n) begin
        if (!link_rst_n)
            sda_oe <= 1'b0;
        else
            sda_oe <= ack_pend | (in_read & ~ack_edge & ~rd_bit);
    end
    assign sda_oe_out = sda_oe;

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in)
            sda_out <= 1'b0; // open drain, only ever pulls low
        else
            sda_out <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // event crossing and register file, core domain
    logic ev_s1, ev_s2, ev_s3;
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in)
            {ev_s1, ev_s2, ev_s3} <= 3'h0;
        else
            {ev_s1, ev_s2, ev_s3} <= {ev_tog, ev_s1, ev_s2};
    end

    logic [6:0] ptr, map_ptr;
    logic [7:0] font_ptr, grid_count, shift_limit;
    logic [3:0] intensity;
    logic blank_pol, run, test;

    wire ev_hit = ev_s2 ^ ev_s3; // kind and byte are stable by now
    wire cmd_go = ev_hit & (ev_kind == VMC_EV_CMD);
    wire wr_go = ev_hit & (ev_kind == VMC_EV_WR);
    wire step = wr_go | (ev_hit & (ev_kind == VMC_EV_RD));
    wire fixed_ptr = (ptr == VMC_REG_FONT) | (ptr == VMC_REG_MAP)
        | (ptr == VMC_REG_HOLD);
    wire [6:0] next_ptr = fixed_ptr ? ptr : ptr + 7'h01;
    wire wr_grid = wr_go & (ptr == VMC_REG_GRID);
    wire wr_cfg = wr_go & (ptr == VMC_REG_CFG);
    wire run_rise = wr_cfg & ev_byte[VMC_RUN_BIT] & ~run;
    wire [7:0] grid_in = (ev_byte > VMC_GRID_MAX) ?
        VMC_GRID_MAX : ev_byte;
    wire [7:0] limit_in = (ev_byte > VMC_LIMIT_MAX) ?
        VMC_LIMIT_MAX : ev_byte;
    wire [7:0] rd_mux =
        (ptr == VMC_REG_POL) ? {6'h00, blank_pol, 1'b0} :
        (ptr == VMC_REG_INT) ? {4'h0, intensity} :
        (ptr == VMC_REG_GRID) ? grid_count :
        (ptr == VMC_REG_CFG) ? {7'h00, run} :
        (ptr == VMC_REG_TEST) ? {VMC_DEV_ID, test} :
        (ptr == VMC_REG_LIMIT) ? shift_limit : 8'h00;

    // pointer and memory pointers
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ptr <= 7'h00;
            font_ptr <= 8'h00;
            map_ptr <= 7'h00;
        end else begin
            if (cmd_go)
                ptr <= ev_byte[6:0];
            else if (step)
                ptr <= next_ptr;
            if (step & (ptr == VMC_REG_FONT))
                font_ptr <= font_ptr + 8'h01;
            if (step & (ptr == VMC_REG_MAP))
                map_ptr <= (map_ptr == VMC_MAP_LAST) ?
                    7'h00 : map_ptr + 7'h01;
        end
    end

    // settings written over the link
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            blank_pol <= 1'b0;
            intensity <= VMC_INT_RST;
            grid_count <= VMC_GRID_RST;
            run <= 1'b0;
            test <= 1'b0;
            shift_limit <= VMC_LIMIT_RST;
        end else if (wr_go) begin
            if (ptr == VMC_REG_POL)
                blank_pol <= ev_byte[VMC_POL_BIT];
            if (ptr == VMC_REG_INT)
                intensity <= ev_byte[3:0];
            if (wr_grid)
                grid_count <= grid_in;
            if (wr_cfg)
                run <= ev_byte[VMC_RUN_BIT];
            if (ptr == VMC_REG_TEST)
                test <= ev_byte[VMC_TEST_BIT];
            if (ptr == VMC_REG_LIMIT)
                shift_limit <= limit_in;
        end
    end

    // read byte kept fresh every cycle; the link samples it much later
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in)
            rd_byte <= 8'h00;
        else
            rd_byte <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////
    // multiplex engine: 16 slots per grid period
    logic [15:0] sc;
    logic [3:0] si;
    logic [5:0] cur_grid;
    logic hold_pend, hold_cur;
    logic shifting;
    logic [1:0] ph;
    logic [6:0] bit_idx;

    wire period_start = run & (si == 4'h0) & (sc == 16'h0000);
    wire slot_end = sc == SLOT_LAST;
    wire [5:0] next_grid = ({2'h0, cur_grid} >= grid_count) ?
        6'h00 : cur_grid + 6'h01;
    wire hold_set = wr_grid | run_rise;
    wire [3:0] eff_int = test ? VMC_TEST_INT : intensity;
    wire [4:0] on_last = (eff_int == VMC_INT_FULL) ?
        5'h0f : {1'b0, eff_int} + 5'h01;
    wire lit = run & ~hold_cur & (si != 4'h0)
        & ({1'b0, si} <= on_last);
    wire load_win = run & (si == 4'h0) & (sc < VMC_LOAD_CYC);
    wire shift_go = run & (si == 4'h0) & (sc == VMC_LOAD_CYC);
    wire last_bit = bit_idx == shift_limit[6:0];
    wire stream_bit = bit_idx == {1'b0, next_grid};

    // slot timing; stopped and cleared while shut down
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sc <= 16'h0000;
            si <= 4'h0;
        end else if (!run) begin
            sc <= 16'h0000;
            si <= 4'h0;
        end else begin
            sc <= slot_end ? 16'h0000 : sc + 16'h0001;
            if (slot_end)
                si <= si + 4'h1;
        end
    end

    // grid stepping and first-cycle blanking; a set beats the clear
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cur_grid <= 6'h00;
            hold_pend <= 1'b0;
            hold_cur <= 1'b1;
        end else begin
            if (!run)
                cur_grid <= 6'h00;
            else if (period_start)
                cur_grid <= next_grid;
            hold_pend <= hold_set | (hold_pend & ~period_start);
            if (period_start)
                hold_cur <= hold_pend | hold_set;
        end
    end

    // shifter: clock at a quarter rate, data moves on the fall
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shifting <= 1'b0;
            ph <= 2'h0;
            bit_idx <= 7'h00;
            tube_shift_clock_out <= 1'b0;
            tube_serial_out_out <= 1'b0;
        end else if (shift_go) begin
            shifting <= 1'b1;
            ph <= 2'h0;
            bit_idx <= 7'h00;
        end else if (shifting) begin
            ph <= ph + 2'h1;
            if (ph == 2'h0) begin
                tube_shift_clock_out <= 1'b0;
                tube_serial_out_out <= stream_bit;
            end
            if (ph == 2'h2)
                tube_shift_clock_out <= 1'b1;
            if (ph == PH_LAST) begin
                bit_idx <= bit_idx + 7'h01;
                if (last_bit)
                    shifting <= 1'b0;
            end
        end else begin
            tube_shift_clock_out <= 1'b0;
        end
    end

    // latch load and blank gate outputs
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tube_latch_load_out <= 1'b0;
            tube_blank_gate_out <= 1'b1;
        end else begin
            tube_latch_load_out <= load_win;
            tube_blank_gate_out <= blank_pol ? lit : ~lit;
        end
    end
endmodule
`default_nettype wire

// ==== verification/vmc_mux_ctrl_properties.sv ====
// port assertions for the vfd multiplex controller
`default_nettype none
module vmc_mux_ctrl_chk #(
    parameter int SLOT_CYCLES = 625
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic tube_shift_clock_out,
    input wire logic tube_serial_out_out,
    input wire logic tube_latch_load_out,
    input wire logic tube_blank_gate_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PERIOD = 16 * SLOT_CYCLES;
    logic load_q;
    logic [15:0] since;
    wire logic ld = tube_latch_load_out;
    wire logic sck = tube_shift_clock_out;
    wire logic sdo = tube_serial_out_out;
    wire logic blk = tube_blank_gate_out;
    wire logic load_rise = ld && !load_q;
    // cycles since last load; saturates so shutdown gaps pass
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            load_q <= 1'b0;
            since <= 16'hffff;
        end else begin
            load_q <= ld;
            if (load_rise) begin
                since <= 16'h0000;
            end else if (since != 16'hffff) begin
                since <= since + 16'h0001;
            end
        end
    end
    ////////////////////////////////
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    sequence load_pulse;
        ld [*4] ##1 !ld;
    endsequence
    sequence clk_high;
        sck [*2] ##1 !sck;
    endsequence
    chk_load_pulse: assert property (
        $rose(ld) |-> load_pulse) else $error("load pulse width wrong");
    chk_load_gap: assert property (
        load_rise |-> since >= PERIOD - 1) else $error("period too short");
    chk_blank_slot0: assert property (
        $rose(ld) |=> $stable(blk) [*8]) else $error("blank moved in slot 0");
    chk_shift_rate: assert property (
        $rose(sck) |-> clk_high) else $error("shift clock rate wrong");
    chk_data_hold: assert property (
        sck |-> $stable(sdo)) else $error("data moved with clock high");
    chk_load_idle: assert property (
        ld |-> !sck) else $error("shifting during load");
    chk_first_bit: assert property (
        $fell(ld) |-> !sck [*3] ##1 $rose(sck)) else $error("first bit late");
    chk_oe_edge: assert property (
        $changed(sda_oe_out) |-> !scl_in) else $error("sda drive moved");
    chk_sda_open: assert property (
        @(posedge scl_in) disable iff (!resetn_in)
        sda_oe_out |-> !sda_out) else $error("sda driven high");
endmodule
`default_nettype wire

// ==== verification/vmc_tube_model.sv ====
// shift-register tube driver model with load latch
`default_nettype none
module vmc_tube_model (
    input wire logic shift_clk_in,
    input wire logic data_in,
    input wire logic load_in,
    output logic [83:0] latch_out,
    output int bits_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [83:0] sr = '0;
    int cnt = 0;
    int base = 0;
    ////////////////////////////////
    // data taken on the rising shift edge
    always @(posedge shift_clk_in) begin
        sr <= {sr[82:0], data_in};
        cnt <= cnt + 1;
    end
    // bits shifted since the previous load
    always @(posedge load_in) begin
        bits_out <= cnt - base;
        base <= cnt;
    end
    // load high passes the register, low holds it
    always_latch begin
        if (load_in) begin
            latch_out <= sr;
        end
    end
endmodule
`default_nettype wire

// ==== verification/test_vmc_mux_ctrl.sv ====
// self-checking bench for the vfd multiplex controller
`default_nettype none
module test_vmc_mux_ctrl
    import vmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SLOT = 32;
    localparam int PER = 16 * SLOT;
    localparam logic [6:0] ADDR = {VMC_ADDR_HI, 2'b10};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic scl = 1'b1;
    logic msda = 1'b1;
    logic oe, so, sck, sdo, ld, blk;
    logic [83:0] latch;
    int bits;
    int mismatches = 0;
    int comparisons = 0;
    // pull-up wire: low when either party pulls it
    wire logic sda = msda & (oe ? so : 1'b1);
    vmc_mux_ctrl #(.SLOT_CYCLES(SLOT)) uut (
        .core_clk_in(clk), .resetn_in(rstn), .scl_in(scl), .sda_in(sda),
        .addr_select_pin_in(2'b10), .sda_out(so), .sda_oe_out(oe),
        .tube_shift_clock_out(sck), .tube_serial_out_out(sdo),
        .tube_latch_load_out(ld), .tube_blank_gate_out(blk));
    vmc_tube_model drv (.shift_clk_in(sck), .data_in(sdo), .load_in(ld),
        .latch_out(latch), .bits_out(bits));
    initial forever #5 clk = ~clk;
    ////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one bit at 48 ns; scl stands still outside frames
    task automatic bit_io(input logic b, output logic r);
        msda = b;
        #12 scl = 1'b1;
        #12 r = sda;
        #12 scl = 1'b0;
        #12;
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
        #60; // core needs time to apply the byte
    endtask
    task automatic rx(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
        #60;
    endtask
    task automatic start();
        #50 msda = 1'b0;
        #50 scl = 1'b0;
        #24;
    endtask
    task automatic stop();
        msda = 1'b0;
        #24 scl = 1'b1;
        #24 msda = 1'b1;
        #200;
    endtask
    task automatic wr(input logic [7:0] c, input int n,
                      input logic [7:0] d0, input logic [7:0] d1);
        logic a;
        start();
        tx({ADDR, 1'b0}, a);
        check(a, 1'b1);
        tx(c, a);
        if (n > 0) tx(d0, a);
        if (n > 1) tx(d1, a);
        stop();
    endtask
    task automatic rd(input int n, output logic [7:0] r0,
                      output logic [7:0] r1);
        logic a;
        start();
        tx({ADDR, 1'b1}, a);
        rx(n == 1, r0);
        if (n > 1) rx(1'b1, r1);
        stop();
    endtask
    // clamps, pointer rules, wrong address, blank polarity
    task automatic regs_test();
        logic [7:0] a, b;
        check(blk, 1'b1);
        check(sck, 1'b0);
        wr(8'h82, 2, 8'h03, 8'h30);
        wr(8'h02, 0, 8'h00, 8'h00);
        rd(2, a, b);
        check(a, 8'h03);
        check(b, 8'h2f);
        wr(8'h0e, 1, 8'h54, 8'h00);
        wr(8'h0e, 0, 8'h00, 8'h00);
        rd(1, a, b);
        check(a, 8'h53);
        // pointer set and read in one frame through a repeated start
        start();
        tx({ADDR, 1'b0}, a[0]);
        tx(8'h03, a[0]);
        #12 scl = 1'b1;
        start();
        tx({ADDR, 1'b1}, a[0]);
        rx(1'b1, b);
        stop();
        check(b, 8'h2f);
        // two bytes at the font location leave the pointer there
        wr(8'h05, 2, 8'h11, 8'h22);
        rd(1, a, b);
        check(a, 8'h00);
        start();
        tx({VMC_ADDR_HI, 2'b01, 1'b0}, a[0]);
        check(a[0], 1'b0);
        stop();
        wr(8'h01, 1, 8'h02, 8'h00);
        check(blk, 1'b0);
        wr(8'h01, 1, 8'h00, 8'h00);
        check(blk, 1'b1);
    endtask
    // count enabled blank cycles up to the next load
    task automatic next_load(output int en);
        logic low;
        en = 0;
        low = 1'b0;
        for (int i = 0; i < 3 * PER; i++) begin
            @(negedge clk);
            if (ld && low) break;
            low = low | !ld;
            en += int'(blk === 1'b0);
        end
    endtask
    // three grids, five bits, intensity 3, then shutdown
    task automatic run_test();
        int en, idx, prev;
        wr(8'h0e, 1, 8'h04, 8'h00);
        wr(8'h02, 2, 8'h03, 8'h02);
        wr(8'h04, 1, 8'h01, 8'h00);
        next_load(en);
        check(en, 0);
        prev = -1;
        for (int k = 0; k < 6; k++) begin
            next_load(en);
            idx = -1;
            for (int i = 0; i < 5; i++) begin
                if (latch[4 - i]) idx = i;
            end
            check($countones(latch[4:0]), 1);
            check(bits, 5);
            check(en, 4 * SLOT);
            if (prev >= 0) check(idx, (prev + 1) % 3);
            prev = idx;
        end
        wr(8'h04, 1, 8'h00, 8'h00);
        repeat (PER) @(negedge clk);
        en = 0;
        repeat (2 * PER) begin
            @(negedge clk);
            en += int'(blk !== 1'b1) + int'(sck !== 1'b0);
        end
        check(en, 0);
    endtask
    ////////////////////////////////
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        regs_test();
        run_test();
        results();
    end
    // watchdog well past the expected run length
    initial begin
        #500000;
        mismatches++;
        results();
    end
endmodule
bind vmc_mux_ctrl vmc_mux_ctrl_chk #(.SLOT_CYCLES(SLOT_CYCLES)) chk (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .tube_shift_clock_out(tube_shift_clock_out),
    .tube_serial_out_out(tube_serial_out_out),
    .tube_latch_load_out(tube_latch_load_out),
    .tube_blank_gate_out(tube_blank_gate_out));
`default_nettype wire
